// *** core/vfei_pkg.sv ***
// Constants for the frame error, sleep and interrupt request block.
// Assumes a 10 MHz clock and AXI4-Lite word access, register index = byte address / 4.
package vfei_pkg;
	// ==================================================
	// Register map (indices)
	localparam int          ADDR_W      = 12;
	localparam logic [7:0]  IDX_CONTROL = 8'hf6;
	localparam logic [7:0]  IDX_ERROR   = 8'hf7;
	localparam logic [7:0]  IDX_VECTOR  = 8'hf8;
	localparam logic [7:0]  IDX_PRIO    = 8'hf9;
	localparam logic [7:0]  IDX_MASK    = 8'hfa;
	localparam logic [7:0]  IDX_OPTIONS = 8'hfb;
	// ==================================================
	// Field positions and reset values
	localparam int          CTL_EN      = 0;
	localparam int          CTL_DIS     = 1;
	localparam int          CTL_NFL     = 2;
	localparam int          OPT_DMA_SUSPEND_SELECT = 5;
	localparam int          ERR_TTO     = 7;
	localparam int          ERR_RECEIVE_OVERFLOW_FLAG    = 5;
	localparam int          ERR_RBRK    = 3;
	localparam int          ERR_CRC_ERROR_FLAG    = 2;
	localparam int          ERR_IFD     = 1;
	localparam int          ERR_IBD     = 0;
	localparam int          MSK_ERR     = 7;
	localparam int          MSK_TRANSMIT_READY_FLAG    = 6;
	localparam int          MSK_RECEIVE_FULL_FLAG    = 5;
	localparam int          MSK_TLA     = 4;
	localparam int          MSK_RXD     = 3;
	localparam int          MSK_END_DATA_MIN_EVENT    = 2;
	localparam int          MSK_END_FRAME_MIN_EVENT    = 1;
	localparam int          MSK_TXD     = 0;
	localparam int          PRIO_SLP    = 4;
	localparam int          PRIO_RX_BLOCK_END_PENDING  = 1;
	localparam int          PRIO_TX_BLOCK_END_PENDING  = 0;
	localparam logic [7:0]  PRIO_RESET  = 8'h10;
	localparam logic [7:0]  MASK_RESET  = 8'h00;
	localparam logic [7:0]  ERROR_RESET = 8'h00;
	localparam logic [7:0]  CTL_RESET   = 8'h00;
	localparam logic [7:0]  OPT_RESET   = 8'h00;
	localparam logic [4:0]  VBASE_RESET = 5'h00;
	localparam logic [2:0]  PRL_NONE    = 3'h7;
	// ==================================================
	// Encoded interrupt sources
	localparam logic [1:0]  SRC_ERR     = 2'h0;
	localparam logic [1:0]  SRC_EOM     = 2'h1;
	localparam logic [1:0]  SRC_RX      = 2'h2;
	localparam logic [1:0]  SRC_TX      = 2'h3;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// ==================================================
	// Timing
	localparam int          CLK_NS      = 100;
	localparam int          TV1_MIN_NS  = 35000;
	localparam int          TV1_CYC     = (TV1_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0]  DIS_CYC     = 3'h6;
	localparam int          FRAME_BYTES = 12;
	localparam logic [6:0]  FRAME_BITS  = 7'(FRAME_BYTES * 8);
	typedef enum logic [1:0] {FR_IDLE, FR_DATA, FR_EOD, FR_LOCK} vfei_frame_e;
endpackage

// *** core/vfei_top.sv ***
// Frame error detection, receiver sleep, vector/priority and DMA/interrupt request logic.
// Assumes symbol events and status levels come from the decoder on aclk; the bus pin is async.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module vfei_top
	import vfei_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              bus_receive_input,
	input  wire logic              sym_sof,
	input  wire logic              sym_data,
	input  wire logic              end_data_min_event,
	input  wire logic              end_frame_min_event,
	input  wire logic              break_active,
	input  wire logic              transmitting,
	input  wire logic              filter_mode,
	input  wire logic              timeout_event,
	input  wire logic              underflow_event,
	input  wire logic              overflow_event,
	input  wire logic              abort_event,
	input  wire logic              crc_fail_event,
	input  wire logic              lost_arbitration_flag,
	input  wire logic              end_data_min_status,
	input  wire logic              end_frame_min_status,
	input  wire logic              receive_full_flag,
	input  wire logic              transmit_ready_flag,
	input  wire logic              rx_dma_last,
	input  wire logic              tx_dma_last,
	input  wire logic              irq_ack,
	output logic                   irq_req,
	output logic                   rx_dma_req,
	output logic                   tx_dma_req,
	output logic [2:0]             priority_level,
	output logic                   receiver_sleep,
	output logic                   rx_load_enable,
	output logic                   rx_flag_enable,
	output logic                   tx_halt,
	output logic                   cancel_queued_tx
);
	// ==================================================
	// Helpers
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a[ADDR_W-1:10] == '0) && (a[1:0] == 2'h0) &&
			(a[9:2] >= IDX_CONTROL) && (a[9:2] <= IDX_OPTIONS);
	endfunction

	function automatic logic [1:0] enc_source(input logic e, input logic m, input logic r);
		enc_source = e ? SRC_ERR : m ? SRC_EOM : r ? SRC_RX : SRC_TX;
	endfunction

	// ==================================================
	// State
	logic              aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0]        wdata_q;
	logic              wstrb0_q;
	logic [1:0]        bresp_q, rresp_q;
	logic [7:0]        rdata_q;
	logic [7:0]        ctl_q, opt_q, mask_q, error_q;
	logic [4:0]        vbase_q;
	logic [1:0]        enc_q;
	logic [1:0]        enc_now;
	logic [2:0]        prl_q;
	logic              sleep_q, rxp_q, txp_q;
	logic [2:0]        dis_cnt_q;
	logic              rx_s1_q, rx_s2_q, rx_s3_q;
	logic [8:0]        hold_q;
	vfei_frame_e       state_q;
	logic [6:0]        bits_q;
	logic              eod_seen_q, eod2_q, lock_ibd_q, cancel_q;

	// ==================================================
	// Register bus decode
	wire         aw_hs    = s_axi_awvalid & s_axi_awready;
	wire         w_hs     = s_axi_wvalid & s_axi_wready;
	wire         ar_hs    = s_axi_arvalid & s_axi_arready;
	wire         wr_fire  = aw_hold_q & w_hold_q & ~bvalid_q;
	wire         wr_ok    = wr_fire & mapped(awaddr_q) & wstrb0_q;
	wire [7:0]   widx     = awaddr_q[9:2];
	wire [7:0]   ridx     = s_axi_araddr[9:2];
	wire         rd_ok    = mapped(s_axi_araddr);
	wire         we_ctl   = wr_ok & (widx == IDX_CONTROL);
	wire         we_vec   = wr_ok & (widx == IDX_VECTOR);
	wire         we_prio  = wr_ok & (widx == IDX_PRIO);
	wire         we_mask  = wr_ok & (widx == IDX_MASK);
	wire         we_opt   = wr_ok & (widx == IDX_OPTIONS);
	wire         rd_err   = ar_hs & rd_ok & (ridx == IDX_ERROR);
	wire [7:0]   prio_rd  = {prl_q, sleep_q, 2'h0, rxp_q, txp_q};
	wire [7:0]   rd_mux   = (ridx == IDX_CONTROL) ? ctl_q :
		(ridx == IDX_ERROR)   ? error_q :
		(ridx == IDX_VECTOR)  ? {vbase_q, enc_q, 1'b0} :
		(ridx == IDX_PRIO)    ? prio_rd :
		(ridx == IDX_MASK)    ? mask_q : opt_q;

	assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
	assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = {24'h000000, rdata_q};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			rvalid_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 8'h00;
			wstrb0_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 8'h00;
		end else begin
			if (aw_hs) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (ar_hs) begin
				rvalid_q <= 1'b1;
				rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
				rdata_q  <= rd_ok ? rd_mux : 8'h00;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ==================================================
	// Enable, disable and sleep
	wire active    = ctl_q[CTL_EN] & ~ctl_q[CTL_DIS];
	wire dis_force = ctl_q[CTL_DIS] & (dis_cnt_q == DIS_CYC - 3'h1);
	wire quiet     = (sleep_q | filter_mode) & ~transmitting;
	wire sl_idle   = sleep_q & ~transmitting;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q     <= CTL_RESET;
			opt_q     <= OPT_RESET;
			dis_cnt_q <= 3'h0;
			sleep_q   <= PRIO_RESET[PRIO_SLP];
		end else begin
			if (we_ctl)
				ctl_q <= wdata_q;
			if (we_opt)
				opt_q <= wdata_q;
			if (!ctl_q[CTL_DIS])
				dis_cnt_q <= 3'h0;
			else if (!dis_force)
				dis_cnt_q <= dis_cnt_q + 3'h1;
			if (!active || timeout_event || (we_prio && wdata_q[PRIO_SLP]))
				sleep_q <= 1'b1;
			else if (end_frame_min_event || break_active)
				sleep_q <= 1'b0;
		end
	end

	assign receiver_sleep = sleep_q;
	assign rx_load_enable = active & ~sleep_q & (state_q != FR_LOCK);
	assign rx_flag_enable = active & ~sl_idle;

	// ==================================================
	// Bus input synchroniser and level hold timer
	wire bit_edge  = rx_s2_q ^ rx_s3_q;
	wire short_bit = bit_edge & (hold_q < 9'(TV1_CYC));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_s1_q <= 1'b0;
			rx_s2_q <= 1'b0;
			rx_s3_q <= 1'b0;
			hold_q  <= 9'(TV1_CYC);
		end else begin
			rx_s1_q <= bus_receive_input;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			if (bit_edge)
				hold_q <= 9'h001;
			else if (hold_q < 9'(TV1_CYC))
				hold_q <= hold_q + 9'h001;
		end
	end

	// ==================================================
	// Frame tracking
	wire eod_bad  = end_data_min_event & ((bits_q == 7'h00) | (bits_q[2:0] != 3'h0));
	wire len_over = sym_data & ~ctl_q[CTL_NFL] & (bits_q == FRAME_BITS);
	wire ifd_cause = ((state_q == FR_IDLE) & sym_data) |
		((state_q == FR_DATA) & (sym_sof | eod_bad | len_over)) |
		((state_q == FR_EOD) & (sym_sof | (eod2_q & sym_data)));
	wire ibd_cause = short_bit & (state_q != FR_LOCK);
	wire ifd_hit   = active & ~quiet & ifd_cause;
	wire ibd_hit   = active & ~quiet & ibd_cause;
	wire err_hit   = ifd_hit | ibd_hit;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q    <= FR_IDLE;
			bits_q     <= 7'h00;
			eod_seen_q <= 1'b0;
			eod2_q     <= 1'b0;
			lock_ibd_q <= 1'b0;
			cancel_q   <= 1'b0;
		end else begin
			cancel_q <= err_hit;
			if (!active) begin
				state_q    <= FR_IDLE;
				lock_ibd_q <= 1'b0;
			end else if (err_hit) begin
				state_q <= FR_LOCK;
				if (ibd_hit)
					lock_ibd_q <= 1'b1;
			end else begin
				unique case (state_q)
					FR_IDLE: begin
						if (sym_sof) begin
							state_q    <= FR_DATA;
							bits_q     <= 7'h00;
							eod_seen_q <= 1'b0;
							eod2_q     <= 1'b0;
						end
					end
					FR_DATA: begin
						if (end_data_min_event) begin
							state_q    <= FR_EOD;
							eod_seen_q <= 1'b1;
							eod2_q     <= eod_seen_q;
						end else if (sym_data && bits_q != FRAME_BITS) begin
							bits_q <= bits_q + 7'h01;
						end
					end
					FR_EOD: begin
						if (end_frame_min_event)
							state_q <= FR_IDLE;
						else if (sym_data)
							state_q <= FR_DATA;
					end
					FR_LOCK: begin
						if (end_frame_min_event) begin
							state_q    <= FR_IDLE;
							lock_ibd_q <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	assign tx_halt          = lock_ibd_q;
	assign cancel_queued_tx = cancel_q;

	// ==================================================
	// Error register
	wire [7:0] err_set = {timeout_event, underflow_event, overflow_event & ~sleep_q,
		abort_event, break_active, crc_fail_event & ~quiet, ifd_hit, ibd_hit};
	wire [7:0] err_keep = {1'b1, 3'h0, break_active, 3'h0};
	wire [7:0] err_clr  = rd_err ? (error_q & ~err_keep) : 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			error_q <= ERROR_RESET;
		else if (!active)
			error_q <= ERROR_RESET;
		else
			error_q <= (error_q & ~err_clr) | err_set;
	end

	// ==================================================
	// Mask, vector, priority and block end pending
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_q  <= MASK_RESET;
			vbase_q <= VBASE_RESET;
			prl_q   <= PRIO_RESET[7:5];
			rxp_q   <= PRIO_RESET[PRIO_RX_BLOCK_END_PENDING];
			txp_q   <= PRIO_RESET[PRIO_TX_BLOCK_END_PENDING];
			enc_q   <= SRC_ERR;
		end else if (dis_force) begin
			mask_q <= MASK_RESET;
			rxp_q  <= 1'b0;
			txp_q  <= 1'b0;
		end else begin
			if (we_mask)
				mask_q <= wdata_q;
			if (rx_dma_last)
				mask_q[MSK_RXD] <= 1'b0;
			if (tx_dma_last)
				mask_q[MSK_TXD] <= 1'b0;
			if (we_vec)
				vbase_q <= wdata_q[7:3];
			if (we_prio)
				prl_q <= wdata_q[7:5];
			if (rx_dma_last)
				rxp_q <= 1'b1;
			else if (we_prio && !wdata_q[PRIO_RX_BLOCK_END_PENDING])
				rxp_q <= 1'b0;
			if (tx_dma_last)
				txp_q <= 1'b1;
			else if (we_prio && !wdata_q[PRIO_TX_BLOCK_END_PENDING])
				txp_q <= 1'b0;
			if (irq_ack)
				enc_q <= enc_now;
		end
	end

	// ==================================================
	// Request arbitration
	wire src_err = (|error_q & mask_q[MSK_ERR]) |
		(lost_arbitration_flag & mask_q[MSK_TLA]);
	wire src_eom = (end_data_min_status & mask_q[MSK_END_DATA_MIN_EVENT]) |
		(end_frame_min_status & mask_q[MSK_END_FRAME_MIN_EVENT]);
	wire src_rx  = ((receive_full_flag & ~mask_q[MSK_RXD]) | rxp_q) & mask_q[MSK_RECEIVE_FULL_FLAG];
	wire src_tx  = ((transmit_ready_flag & ~mask_q[MSK_TXD]) | txp_q) & mask_q[MSK_TRANSMIT_READY_FLAG];
	wire suspend = opt_q[OPT_DMA_SUSPEND_SELECT] & (|error_q | lost_arbitration_flag);
	assign enc_now = enc_source(src_err, src_eom, src_rx);

	assign tx_dma_req = active & transmit_ready_flag & mask_q[MSK_TXD] & ~suspend;
	assign rx_dma_req = active & receive_full_flag & mask_q[MSK_RXD] & ~suspend & ~tx_dma_req;
	assign irq_req    = active & (src_err | src_eom | src_rx | src_tx) &
		~tx_dma_req & ~rx_dma_req & (prl_q != PRL_NONE);
	assign priority_level = prl_q;

	// ==================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_dis_held;
		ctl_q[CTL_DIS] [*6];
	endsequence

	a_ifd_sof_mid: assert property (active && !quiet && state_q == FR_DATA && sym_sof
		|=> error_q[ERR_IFD] && state_q == FR_LOCK) else $error("ifd not set on sof mid-data");
	a_ifd_length: assert property (active && !quiet && state_q == FR_DATA && len_over
		|=> error_q[ERR_IFD]) else $error("ifd not set on long frame");
	a_ifd_second_eod: assert property (active && !quiet && state_q == FR_EOD && eod2_q
		&& sym_data |=> error_q[ERR_IFD]) else $error("ifd not set on second eod");
	a_err_once: assert property (state_q == FR_LOCK && !end_frame_min_event && active
		|=> !cancel_q) else $error("second error in one frame");
	a_error_held: assert property (!active |=> error_q == 8'h00)
		else $error("error flags not held clear");
	a_ibd_short: assert property (active && !quiet && short_bit && state_q != FR_LOCK
		|=> error_q[ERR_IBD] ##0 tx_halt) else $error("ibd not set on short level");
	a_sleep_hold: assert property (!active |=> sleep_q [*2] or !active)
		else $error("sleep not set while disabled");
	a_sleep_wake: assert property (active && end_frame_min_event && !timeout_event
		&& !we_prio |=> !sleep_q) else $error("sleep not cleared at end of frame");
	a_rx_eob: assert property (rx_dma_last && !dis_force
		|=> rxp_q && !mask_q[MSK_RXD]) else $error("rx block end not handled");
	a_tx_eob: assert property (tx_dma_last && !dis_force
		|=> txp_q && !mask_q[MSK_TXD]) else $error("tx block end not handled");
	a_dis_force: assert property (s_dis_held |=> mask_q == MASK_RESET && !rxp_q && !txp_q)
		else $error("disable did not force mask");
	a_vec_ack: assert property (irq_ack && src_err && !dis_force
		|=> enc_q == SRC_ERR) else $error("source code not captured");
endmodule

// *** testbench/vfei_xcvr_model.sv ***
// Bus transceiver stand-in: drives the filtered receive level.
// Assumes one pulse request at a time; idle level is passive low.
`timescale 1ns/10ps
module vfei_xcvr_model (
	input  wire logic       aclk,
	input  wire logic       start,
	input  wire logic [9:0] len,
	output logic            bus_level
);
	// ==========
	// Pulse timer
	logic [9:0] cnt_q = 10'h000;
	always @(posedge aclk) begin
		if (start) begin
			cnt_q <= (len < 10'h046) ? 10'h046 : len;
		end else if (cnt_q != 10'h000) begin
			cnt_q <= cnt_q - 10'h001;
		end
	end
	assign bus_level = (cnt_q != 10'h000);
endmodule

// *** testbench/vpw_frame_error_irq_logic_tb.sv ***
// Self-checking bench for the frame error and interrupt request block.
// Assumes the design package and a transceiver model beside it.
`timescale 1ns/10ps
module vpw_frame_error_irq_logic_tb;
	import vfei_pkg::*;
	// ==========
	// Signals
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic bus_receive_input, sym_sof, sym_data, end_data_min_event, end_frame_min_event;
	logic break_active, transmitting, filter_mode, timeout_event, underflow_event;
	logic overflow_event, abort_event, crc_fail_event, lost_arbitration_flag;
	logic end_data_min_status, end_frame_min_status, receive_full_flag, transmit_ready_flag;
	logic rx_dma_last, tx_dma_last, irq_ack, irq_req, rx_dma_req, tx_dma_req, receiver_sleep;
	logic rx_load_enable, rx_flag_enable, tx_halt, cancel_queued_tx, xstart;
	logic [2:0]  priority_level;
	logic [9:0]  xlen;
	logic [11:0] ev;
	logic [4:0]  smp;
	logic [65:0] e;
	logic [65:0] rq[$];
	logic [1:0]  bq[$];
	logic [31:0] seed;
	int          n_errors, checks, k;
	int          cyc = 0;
	assign {timeout_event, underflow_event, overflow_event, abort_event, crc_fail_event, sym_data,
		sym_sof, end_data_min_event, end_frame_min_event, irq_ack, rx_dma_last, tx_dma_last} = ev;
	assign {break_active, filter_mode, lost_arbitration_flag, end_data_min_status,
		end_frame_min_status} = 5'h00;
	vfei_top dut (.*);
	vfei_xcvr_model xcvr (.aclk(aclk), .start(xstart), .len(xlen), .bus_level(bus_receive_input));
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// ==========
	// Tasks
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
		@(posedge aclk);
		bq.push_back(r);
		s_axi_awaddr <= {2'h0, i, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (smp[4]) s_axi_awvalid <= 1'b0;
			if (smp[3]) s_axi_wvalid <= 1'b0;
		end while (!smp[2]);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] x, input logic [7:0] m,
		input logic [1:0] r);
		@(posedge aclk);
		rq.push_back({24'h000000, x & m, 24'h000000, m, r});
		s_axi_araddr <= {2'h0, i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (smp[1]) s_axi_arvalid <= 1'b0;
		end while (!smp[0]);
		s_axi_rready <= 1'b0;
	endtask
	task automatic pulse(input int n);
		@(posedge aclk);
		ev[n] <= 1'b1;
		@(posedge aclk);
		ev[n] <= 1'b0;
		@(negedge aclk);
	endtask
	// ==========
	// Monitor and timeout
	always @(negedge aclk) begin
		smp <= {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid};
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
			e = rq.pop_front();
			chk("rdata", e[65:34], s_axi_rdata & e[33:2]);
			chk("rresp", {30'h0, e[1:0]}, {30'h0, s_axi_rresp});
		end
		if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
			chk("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
		end
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	// ==========
	// Scenarios
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, ev, xstart, xlen} = '0;
		{transmitting, receive_full_flag, transmit_ready_flag} = '0;
		s_axi_wstrb = 4'hf;
		n_errors = 0;
		checks = 0;
		seed = 32'h00010a10;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(IDX_PRIO, PRIO_RESET, 8'hff, RESP_OKAY);
		rd(IDX_MASK, MASK_RESET, 8'hff, RESP_OKAY);
		rd(IDX_ERROR, 8'h00, 8'hff, RESP_OKAY);
		rd(8'h10, 8'h00, 8'hff, RESP_SLVERR);
		wr(8'h10, 8'hff, RESP_SLVERR);
		wr(IDX_CONTROL, 8'h01, RESP_OKAY);
		wr(IDX_PRIO, 8'h00, RESP_OKAY);
		rd(IDX_PRIO, 8'h10, 8'h10, RESP_OKAY);
		pulse(3);
		rd(IDX_PRIO, 8'h00, 8'h10, RESP_OKAY);
		seed = xs(seed);
		wr(IDX_VECTOR, seed[7:0], RESP_OKAY);
		rd(IDX_VECTOR, seed[7:0], 8'hf8, RESP_OKAY);
		for (k = 0; k < 4; k++) begin
			pulse(10 - k);
			rd(IDX_ERROR, (k == 3) ? 8'h04 : 8'h40 >> k, 8'hff, RESP_OKAY);
			rd(IDX_ERROR, 8'h00, 8'hff, RESP_OKAY);
		end
		for (k = 0; k < 2; k++) begin
			if (k == 0) pulse(6);
			else begin
				pulse(5);
				pulse(5);
			end
			wr(IDX_MASK, 8'h80, RESP_OKAY);
			@(negedge aclk);
			chk("irq_req", 1, {31'h0, irq_req});
			pulse(2);
			rd(IDX_VECTOR, {5'h00, SRC_ERR, 1'b0}, 8'h06, RESP_OKAY);
			rd(IDX_ERROR, 8'h02, 8'hff, RESP_OKAY);
			rd(IDX_ERROR, 8'h00, 8'hff, RESP_OKAY);
			@(negedge aclk);
			chk("irq_req", 0, {31'h0, irq_req});
			pulse(3);
		end
		transmit_ready_flag <= 1'b1;
		wr(IDX_MASK, 8'h40, RESP_OKAY);
		pulse(2);
		rd(IDX_VECTOR, {5'h00, SRC_TX, 1'b0}, 8'h06, RESP_OKAY);
		transmit_ready_flag <= 1'b0;
		repeat (400) @(posedge aclk);
		xlen <= 10'h064;
		xstart <= 1'b1;
		@(posedge aclk);
		xstart <= 1'b0;
		repeat (110) @(posedge aclk);
		rd(IDX_ERROR, 8'h01, 8'h01, RESP_OKAY);
		@(negedge aclk);
		chk("tx_halt", 1, {31'h0, tx_halt});
		pulse(3);
		chk("tx_halt", 0, {31'h0, tx_halt});
		wr(IDX_PRIO, 8'h10, RESP_OKAY);
		transmitting <= 1'b1;
		pulse(6);
		rd(IDX_ERROR, 8'h02, 8'h03, RESP_OKAY);
		transmitting <= 1'b0;
		pulse(3);
		wr(IDX_PRIO, 8'h10, RESP_OKAY);
		pulse(6);
		rd(IDX_ERROR, 8'h00, 8'h03, RESP_OKAY);
		chk("rx_load", 0, {31'h0, rx_load_enable});
		pulse(3);
		for (k = 0; k < 2; k++) begin
			wr(IDX_MASK, (k == 1) ? 8'h01 : 8'h08, RESP_OKAY);
			receive_full_flag <= (k == 0);
			transmit_ready_flag <= (k == 1);
			@(negedge aclk);
			chk("dma_req", 1, {31'h0, (k == 1) ? tx_dma_req : rx_dma_req});
			pulse(1 - k);
			rd(IDX_PRIO, (k == 1) ? 8'h01 : 8'h02, 8'h03, RESP_OKAY);
			rd(IDX_MASK, 8'h00, 8'h09, RESP_OKAY);
			wr(IDX_PRIO, 8'h00, RESP_OKAY);
			rd(IDX_PRIO, 8'h00, 8'h03, RESP_OKAY);
			{receive_full_flag, transmit_ready_flag} <= 2'h0;
		end
		wr(IDX_PRIO, 8'he0, RESP_OKAY);
		@(negedge aclk);
		chk("prl", 32'h7, {29'h0, priority_level});
		wr(IDX_MASK, 8'hff, RESP_OKAY);
		pulse(1);
		pulse(10);
		wr(IDX_CONTROL, 8'h03, RESP_OKAY);
		repeat (7) @(posedge aclk);
		wr(IDX_CONTROL, 8'h01, RESP_OKAY);
		rd(IDX_MASK, 8'h00, 8'hff, RESP_OKAY);
		rd(IDX_PRIO, 8'h10, 8'h13, RESP_OKAY);
		rd(IDX_ERROR, 8'h00, 8'hff, RESP_OKAY);
		repeat (4) @(posedge aclk);
		end_of_test();
	end
endmodule
